// ---- pkg/sfr_pkg.sv ----
// Purpose: Shared constants and types for the serial flash read and status block
// Assumes: Core clock of 200 MHz, serial clock well below a quarter of it
// Notes: Status layout is carried as one packed struct
//
// Overview of operation
// R1: Normal read is opcode 03h then three address bytes, high byte first.
// R2: Normal read data starts on falling edge of the fourth byte's last bit.
// R3: Fast read is opcode 0Bh, three address bytes, then one dummy byte.
// R4: Fast read data starts on falling edge of the fifth byte's last bit.
// R5: Continued clocking advances the read address and streams further bytes.
// R6: Read address wraps from 7FFFFh back to 00000h.
// R7: Raising chip select deselects the device and ends the read.
// R8: Serial output is high impedance whenever chip select is high.
// R9: An eight bit status register is readable through a dedicated command.
// R10: Status write changes only the protection bits; others stay read-only.
// R11: Status bit 7 locks status writes when set; the code blocks them only while spi_wp_n is low.
// R12: Status bit 5 selects upper or lower end for block protection.
// R13: Bits 0, 1, 6 clear at power-on; bit 6 reads zero; others restored.
// R14: Status bit 0 reads 1 while an internal write runs, else 0.
// R15: Opcode 06h sets write-enable latch bit 1; opcode 04h clears it.
// R16: Opcode 05h shifts status out from bit 7, repeating while clocked.
// R17: Address bits 23 down to 19 are ignored.
package sfr_pkg;
   localparam int ADDR_W = 19;
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
   localparam logic [7:0] OP_WRITE_EN = 8'h06;
   localparam logic [7:0] OP_WRITE_DIS = 8'h04;
   localparam int CLK_MHZ = 200;
   localparam int SRW_TIME_US = 10;
   localparam int SRW_CYC = SRW_TIME_US * CLK_MHZ;
   localparam int TMR_W = 12;
   localparam logic [TMR_W-1:0] SRW_LOAD = TMR_W'(SRW_CYC - 1);
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] SYNC_RST = 4'hF;

   typedef struct packed {
      logic lock;
      logic rsv;
      logic side;
      logic [2:0] level;
      logic wel;
      logic busy;
   } sfr_status_t;

   localparam sfr_status_t STATUS_RST = 8'h00;

   typedef enum logic [2:0] {
      ST_CMD = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_READ = 3'b011,
      ST_STAT = 3'b100,
      ST_SRDATA = 3'b101,
      ST_IGNORE = 3'b110
   } sfr_state_t;
endpackage

// ---- src/sfr_fifo.sv ----
// Purpose: Read data buffer between array prefetch and serial shifter
// Assumes: Depth is a power of two
// Notes: Flush empties the buffer in one cycle
`timescale 1ns/100ps
module sfr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("FIFO depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = cnt_q != FULL;
   assign out_valid = cnt_q != '0;
   assign out_data = mem_q[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (flush) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         unique case ({push, pop})
            2'b10: cnt_q <= cnt_q + 1'b1;
            2'b01: cnt_q <= cnt_q - 1'b1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end
endmodule

// ---- src/sfr_array.sv ----
// Purpose: Byte array of the memory with synchronous read
// Assumes: Write port is a preload path only
// Notes: Read data appears one cycle after the request
`timescale 1ns/100ps
module sfr_array #(
   parameter int AW = 19
) (
   input wire logic clk,
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [7:0] wr_data
);
   if (AW < 1 || AW > 24) begin : g_chk
      $error("Array address width out of range");
   end

   logic [7:0] mem_q [2**AW];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_q[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem_q[rd_addr];
      end
   end
endmodule

// ---- src/sfr_top.sv ----
// Purpose: Serial flash slave for array reads and the status register
// Assumes: Serial clock below about 25 MHz so synchronised edges are seen
// Notes: Mode 0 and mode 3 work since only counted rising edges shift in
`timescale 1ns/100ps
module sfr_top (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_si,
   input wire logic spi_wp_n,
   output logic spi_so,
   output logic spi_so_oe,
   input wire sfr_pkg::sfr_status_t nv_init,
   output sfr_pkg::sfr_status_t status_o,
   input wire logic load_en,
   input wire logic [sfr_pkg::ADDR_W-1:0] load_addr,
   input wire logic [7:0] load_data
);
   localparam int AW = sfr_pkg::ADDR_W;

   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic cs_s;
   logic sck_s;
   logic si_s;
   logic wp_s;
   logic sck_prev_q;
   logic cs_prev_q;
   logic rise_e;
   logic fall_e;
   logic cs_rise;
   logic [7:0] sh_q;
   logic [2:0] bit_q;
   logic [7:0] rx_byte;
   logic byte_done;
   sfr_pkg::sfr_state_t state_q;
   logic fast_q;
   logic [1:0] acnt_q;
   logic [23:0] addr_q;
   logic fetch_start;
   logic [AW-1:0] start_addr;
   logic [AW-1:0] fetch_addr_q;
   logic fetch_on_q;
   logic pend_q;
   logic issue;
   logic [7:0] arr_data;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic tx_go;
   logic tx_en_q;
   logic tx_stat_q;
   logic [2:0] tx_cnt_q;
   logic [6:0] tx_sh_q;
   logic [7:0] tx_byte;
   logic pop;
   logic cmd_wren;
   logic cmd_wrdi;
   logic [7:0] srdata_q;
   logic srfull_q;
   logic sw_req;
   logic sw_go;
   logic [sfr_pkg::TMR_W-1:0] tmr_q;
   logic sw_done;
   logic [sfr_pkg::TMR_W-1:0] busy_len_q;
   logic init_q;
   sfr_pkg::sfr_status_t status_q;

   ////////////////////////////////////////////////////////////////////////
   // Reset release and pin synchronisers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= sfr_pkg::SYNC_RST;
         sync2_q <= sfr_pkg::SYNC_RST;
      end else begin
         sync1_q <= {spi_wp_n, spi_si, spi_sck, spi_cs_n};
         sync2_q <= sync1_q;
      end
   end
   assign cs_s = sync2_q[0];
   assign sck_s = sync2_q[1];
   assign si_s = sync2_q[2];
   assign wp_s = sync2_q[3];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_s;
         cs_prev_q <= cs_s;
      end
   end
   assign rise_e = !cs_s && sck_s && !sck_prev_q;
   assign fall_e = !cs_s && !sck_s && sck_prev_q;
   assign cs_rise = cs_s && !cs_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // Serial input, byte framing
   assign rx_byte = {sh_q[6:0], si_s};
   assign byte_done = rise_e && bit_q == 3'h7;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_q <= 8'h00;
         bit_q <= 3'h0;
      end else if (cs_s) begin
         bit_q <= 3'h0;
      end else if (rise_e) begin
         sh_q <= rx_byte;
         bit_q <= bit_q + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command sequencer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= sfr_pkg::ST_CMD;
         fast_q <= 1'b0;
         acnt_q <= 2'h0;
         addr_q <= 24'h000000;
      end else if (cs_s) begin
         state_q <= sfr_pkg::ST_CMD; // R7
      end else if (byte_done) begin
         unique case (state_q)
            sfr_pkg::ST_CMD: begin
               acnt_q <= 2'h0;
               fast_q <= rx_byte == sfr_pkg::OP_FAST_READ; // R3
               if (rx_byte == sfr_pkg::OP_READ || rx_byte == sfr_pkg::OP_FAST_READ) state_q <= sfr_pkg::ST_ADDR; // R1
               else if (rx_byte == sfr_pkg::OP_STATUS_READ) state_q <= sfr_pkg::ST_STAT;
               else if (rx_byte == sfr_pkg::OP_STATUS_WRITE) state_q <= sfr_pkg::ST_SRDATA;
               else state_q <= sfr_pkg::ST_IGNORE;
            end
            sfr_pkg::ST_ADDR: begin
               addr_q <= {addr_q[15:0], rx_byte}; // R1
               acnt_q <= acnt_q + 2'h1;
               if (acnt_q == 2'h2) state_q <= fast_q ? sfr_pkg::ST_DUMMY : sfr_pkg::ST_READ; // R3
            end
            sfr_pkg::ST_DUMMY: state_q <= sfr_pkg::ST_READ; // R3
            sfr_pkg::ST_SRDATA: state_q <= sfr_pkg::ST_IGNORE;
            sfr_pkg::ST_READ, sfr_pkg::ST_STAT, sfr_pkg::ST_IGNORE: state_q <= state_q;
            default: state_q <= sfr_pkg::ST_IGNORE;
         endcase
      end
   end

   assign fetch_start = byte_done && state_q == sfr_pkg::ST_ADDR && acnt_q == 2'h2;
   assign start_addr = {addr_q[10:0], rx_byte}; // R17
   assign cmd_wren = byte_done && state_q == sfr_pkg::ST_CMD && rx_byte == sfr_pkg::OP_WRITE_EN;
   assign cmd_wrdi = byte_done && state_q == sfr_pkg::ST_CMD && rx_byte == sfr_pkg::OP_WRITE_DIS;
   assign tx_go = byte_done && ((fetch_start && !fast_q) || state_q == sfr_pkg::ST_DUMMY
      || (state_q == sfr_pkg::ST_CMD && rx_byte == sfr_pkg::OP_STATUS_READ));

   ////////////////////////////////////////////////////////////////////////
   // Array prefetch into the buffer
   assign issue = fetch_on_q && !pend_q && fifo_in_ready && !cs_s && !fetch_start;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fetch_addr_q <= '0;
         fetch_on_q <= 1'b0;
         pend_q <= 1'b0;
      end else if (fetch_start) begin
         fetch_addr_q <= start_addr;
         fetch_on_q <= 1'b1;
         pend_q <= 1'b0;
      end else if (cs_s) begin
         fetch_on_q <= 1'b0; // R7
         pend_q <= 1'b0;
      end else begin
         pend_q <= issue;
         if (issue) fetch_addr_q <= fetch_addr_q + 1'b1; // R5 R6
      end
   end

   sfr_array #(.AW(AW)) u_array (
      .clk(core_clk),
      .rd_en(issue),
      .rd_addr(fetch_addr_q),
      .rd_data(arr_data),
      .wr_en(load_en),
      .wr_addr(load_addr),
      .wr_data(load_data)
   );

   sfr_fifo #(.WIDTH(8), .DEPTH(sfr_pkg::FIFO_DEPTH)) u_fifo (
      .clk(core_clk),
      .rst_n(rst_n),
      .flush(fetch_start || cs_s),
      .in_valid(pend_q),
      .in_ready(fifo_in_ready),
      .in_data(arr_data),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Serial output on falling edges
   assign tx_byte = tx_stat_q ? status_q : (fifo_out_valid ? fifo_out_data : 8'h00); // R16
   assign pop = fall_e && tx_en_q && !tx_stat_q && tx_cnt_q == 3'h0; // R5

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_en_q <= 1'b0;
         tx_stat_q <= 1'b0;
      end else if (cs_s) begin
         tx_en_q <= 1'b0;
      end else if (tx_go) begin
         tx_en_q <= 1'b1; // R2 R4
         tx_stat_q <= state_q == sfr_pkg::ST_CMD; // R16
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         spi_so <= 1'b0;
         spi_so_oe <= 1'b0;
         tx_cnt_q <= 3'h0;
         tx_sh_q <= 7'h00;
      end else if (cs_s) begin
         spi_so_oe <= 1'b0; // R8
         tx_cnt_q <= 3'h0;
      end else if (fall_e && tx_en_q) begin
         spi_so_oe <= 1'b1; // R2 R4
         tx_cnt_q <= tx_cnt_q + 3'h1;
         if (tx_cnt_q == 3'h0) begin
            spi_so <= tx_byte[7];
            tx_sh_q <= tx_byte[6:0];
         end else begin
            spi_so <= tx_sh_q[6];
            tx_sh_q <= {tx_sh_q[5:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status write capture and busy timer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         srdata_q <= 8'h00;
         srfull_q <= 1'b0;
      end else if (byte_done && state_q == sfr_pkg::ST_SRDATA) begin
         srdata_q <= rx_byte;
         srfull_q <= 1'b1;
      end else if (byte_done || cs_s) begin
         srfull_q <= 1'b0;
      end
   end

   assign sw_req = cs_rise && srfull_q && bit_q == 3'h0;
   assign sw_go = sw_req && status_q.wel && !status_q.busy && !(status_q.lock && !wp_s); // R11
   assign sw_done = status_q.busy && tmr_q == '0;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) tmr_q <= '0;
      else if (sw_go) tmr_q <= sfr_pkg::SRW_LOAD;
      else if (tmr_q != '0) tmr_q <= tmr_q - 1'b1;
   end

   // Busy cycle count, checked against the write time
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) busy_len_q <= '0;
      else if (status_q.busy) busy_len_q <= busy_len_q + 1'b1;
      else busy_len_q <= '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Status register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= sfr_pkg::STATUS_RST; // R13
         init_q <= 1'b0;
      end else begin
         init_q <= 1'b1;
         status_q.rsv <= 1'b0; // R13
         if (!init_q) begin
            status_q.lock <= nv_init.lock; // R13
            status_q.side <= nv_init.side;
            status_q.level <= nv_init.level;
         end else if (sw_go) begin
            status_q.lock <= srdata_q[7]; // R10 R11
            status_q.side <= srdata_q[5]; // R12
            status_q.level <= srdata_q[4:2]; // R10
         end
         if (sw_go) status_q.busy <= 1'b1; // R14
         else if (sw_done) status_q.busy <= 1'b0; // R14
         if (cmd_wren) status_q.wel <= 1'b1; // R15
         else if (cmd_wrdi || sw_done) status_q.wel <= 1'b0; // R15
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) status_o <= sfr_pkg::STATUS_RST;
      else status_o <= status_q; // R9
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_so_hiz_desel: assert property (cs_s |=> !spi_so_oe) // R8
      else $error("Output enabled while deselected");
   a_tx_first_edge: assert property (fall_e && tx_en_q |=> spi_so_oe) // R2 R4
      else $error("Output not driven on data falling edge");
   a_start_addr: assert property (fetch_start |=> fetch_addr_q == $past(start_addr)) // R17
      else $error("Read start address wrong");
   a_addr_incr: assert property (issue |=> fetch_addr_q == $past(fetch_addr_q) + 1'b1) // R5
      else $error("Read address did not advance");
   a_addr_wrap: assert property (issue && fetch_addr_q == '1 |=> fetch_addr_q == '0) // R6
      else $error("Read address did not wrap");
   a_wel_set: assert property (cmd_wren |=> status_q.wel) // R15
      else $error("Write enable latch not set");
   a_wel_clear: assert property (cmd_wrdi |=> !status_q.wel) // R15
      else $error("Write enable latch not cleared");
   a_lock_blocks: assert property (sw_req && status_q.lock && !wp_s && !status_q.busy |=> !status_q.busy) // R11
      else $error("Locked status write started");
   a_busy_hold: assert property ($rose(status_q.busy) |-> status_q.busy [*8]) // R14
      else $error("Busy dropped too early");
   a_busy_end: assert property (sw_done |=> !status_q.busy) // R14
      else $error("Busy did not end");
   a_busy_length: assert property ($fell(status_q.busy) |-> busy_len_q == sfr_pkg::TMR_W'(sfr_pkg::SRW_CYC)) // R14
      else $error("Busy time wrong");
   a_nv_commit: assert property (sw_go |=> status_q.lock == $past(srdata_q[7]) // R10 R12
      && status_q.side == $past(srdata_q[5]) && status_q.level == $past(srdata_q[4:2]))
      else $error("Protection bits not written");
   a_rsv_zero: assert property (##1 !status_o.rsv) // R13
      else $error("Reserved bit set");

   c_normal_read: cover property (fetch_start && !fast_q ##[1:300] pop);
   c_fast_read: cover property (byte_done && state_q == sfr_pkg::ST_DUMMY);
   c_status_read: cover property (tx_go && state_q == sfr_pkg::ST_CMD);
   c_status_write: cover property (sw_go);
endmodule

// ---- verification/sfr_host_model.sv ----
// Purpose: Serial host model driving select, clock and data into the flash block
// Assumes: Mode 0 framing, half clock period of 8 core cycles
// Notes: Serial clock stands low outside frames; released data line toggles
`timescale 1ns/100ps
module sfr_host_model (
   input wire logic core_clk,
   output logic spi_cs_n,
   output logic spi_sck,
   output logic spi_si,
   input wire logic spi_so,
   input wire logic spi_so_oe
);
   logic [7:0] txq[$];
   logic [7:0] rxq[$];
   logic oe_last;

   initial begin
      spi_cs_n = 1'b1;
      spi_sck = 1'b0;
      spi_si = 1'b0;
      oe_last = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // One frame of nbytes; bytes past the queue carry the filler
   task automatic frame(input int nbytes, input logic [7:0] fill);
      logic [7:0] tx;
      logic [7:0] rx;
      rxq.delete();
      @(posedge core_clk);
      spi_cs_n <= 1'b0;
      wait_clk(8);
      for (int i = 0; i < nbytes; i++) begin
         tx = (i < txq.size()) ? txq[i] : fill;
         for (int b = 7; b >= 0; b--) begin
            spi_sck <= 1'b0;
            spi_si <= tx[b];
            wait_clk(8);
            // Undriven line reads back as the inverse
            rx[b] = spi_so_oe ? spi_so : !spi_so;
            oe_last = spi_so_oe;
            spi_sck <= 1'b1;
            wait_clk(8);
         end
         rxq.push_back(rx);
      end
      spi_sck <= 1'b0;
      spi_si <= ~spi_si;
      wait_clk(8);
      spi_cs_n <= 1'b1;
      wait_clk(16);
   endtask
endmodule

// ---- verification/spi_flash_read_status_tb.sv ----
// Purpose: Self-checking bench for array reads and the status register
// Assumes: Host model frames at 8 core cycles per half serial clock
// Notes: Only preloaded addresses are compared
`timescale 1ns/100ps
module spi_flash_read_status_tb;
   logic core_clk;
   logic reset_n;
   logic spi_cs_n;
   logic spi_sck;
   logic spi_si;
   logic spi_wp_n;
   logic spi_so;
   logic spi_so_oe;
   sfr_pkg::sfr_status_t nv_init;
   sfr_pkg::sfr_status_t status_o;
   logic load_en;
   logic [sfr_pkg::ADDR_W-1:0] load_addr;
   logic [7:0] load_data;
   logic [7:0] mem [bit [18:0]];
   logic [31:0] seed;
   logic [7:0] exp_st;
   logic [7:0] d;
   logic [23:0] a;
   int num_errors;
   int n_tests;

   sfr_top uut (.core_clk(core_clk), .reset_n(reset_n), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
      .spi_si(spi_si), .spi_wp_n(spi_wp_n), .spi_so(spi_so), .spi_so_oe(spi_so_oe), .nv_init(nv_init),
      .status_o(status_o), .load_en(load_en), .load_addr(load_addr), .load_data(load_data));

   sfr_host_model host (.core_clk(core_clk), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck), .spi_si(spi_si),
      .spi_so(spi_so), .spi_so_oe(spi_so_oe));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic preload(input logic [18:0] p, input int n);
      logic [7:0] v;
      for (int i = 0; i < n; i++) begin
         v = 8'(rnd());
         @(posedge core_clk);
         load_en <= 1'b1;
         load_addr <= p;
         load_data <= v;
         mem[p] = v;
         @(posedge core_clk);
         load_en <= 1'b0;
         p = p + 19'h1;
      end
   endtask

   // Read n bytes and compare against the mirror, wrapping at the top
   task automatic rd(input logic [7:0] op, input logic [23:0] addr, input int n);
      logic [18:0] p;
      int hdr;
      host.txq = '{op, addr[23:16], addr[15:8], addr[7:0]};
      if (op == sfr_pkg::OP_FAST_READ) begin
         host.txq.push_back(8'(rnd()));
      end
      hdr = host.txq.size();
      host.frame(hdr + n, 8'(rnd()));
      p = addr[18:0];
      for (int i = 0; i < n; i++) begin
         chk(host.rxq[hdr + i], mem[p]);
         p = p + 19'h1;
      end
      chk(8'(host.oe_last), 8'h01);
      chk(8'(spi_so_oe), 8'h00);
   endtask

   task automatic cmd1(input logic [7:0] op);
      host.txq = '{op};
      host.frame(1, 8'h00);
   endtask

   task automatic sw(input logic [7:0] v);
      host.txq = '{sfr_pkg::OP_STATUS_WRITE, v};
      host.frame(2, 8'h00);
   endtask

   task automatic st_read(input logic [7:0] exp);
      host.txq = '{sfr_pkg::OP_STATUS_READ};
      host.frame(3, 8'(rnd()));
      chk(host.rxq[1], exp);
      chk(host.rxq[2], exp);
   endtask

   task automatic wait_idle();
      int i;
      i = 0;
      while (status_o.busy !== 1'b0 && i < 3000) begin
         @(posedge core_clk);
         i++;
      end
      if (i >= 3000) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, status_o, 8'h00);
         give_verdict();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'd88;
      num_errors = 0;
      n_tests = 0;
      reset_n = 1'b0;
      spi_wp_n = 1'b1;
      load_en = 1'b0;
      load_addr = '0;
      load_data = 8'h00;
      // Read-only bits set in the image must not show
      nv_init = 8'(rnd()) | 8'h43;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      exp_st = nv_init & 8'hBC;
      chk(status_o, exp_st);
      $display("test reset done");

      for (int k = 0; k < 4; k++) begin
         a = (k < 2) ? 24'(rnd()) : 24'h07FFFC + 24'(k);
         a[23:19] = 5'(rnd());
         preload(a[18:0], 6);
         rd(k[0] ? sfr_pkg::OP_FAST_READ : sfr_pkg::OP_READ, a, 6);
      end
      $display("test reads done");

      cmd1(sfr_pkg::OP_WRITE_EN);
      chk(status_o, exp_st | 8'h02);
      st_read(exp_st | 8'h02);
      cmd1(sfr_pkg::OP_WRITE_DIS);
      chk(status_o, exp_st);
      sw(8'hFF);
      chk(status_o, exp_st);
      $display("test write latch done");

      d = 8'(rnd()) | 8'hC3;
      cmd1(sfr_pkg::OP_WRITE_EN);
      sw(d);
      chk(status_o, (d & 8'hBC) | 8'h03);
      st_read((d & 8'hBC) | 8'h03);
      wait_idle();
      exp_st = d & 8'hBC;
      chk(status_o, exp_st);
      $display("test status write done");

      spi_wp_n <= 1'b0;
      cmd1(sfr_pkg::OP_WRITE_EN);
      sw(~d);
      chk(status_o, exp_st | 8'h02);
      spi_wp_n <= 1'b1;
      sw(~d);
      chk(status_o, (~d & 8'hBC) | 8'h03);
      wait_idle();
      chk(status_o, ~d & 8'hBC);
      $display("test lock done");
      give_verdict();
   end
endmodule
